// >>> rtl/_unused_placeholder_none.sv
// no further logic
`timescale 1ns/1ps

// >>> rtl/tcc_pkg.sv
// shared constants and types of the tape channel command/status block
package tcc_pkg;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_INIT_STAT = 8'h04;
  localparam logic [7:0] ADDR_END_STAT = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int CMD_PAR_BIT = 8;
  localparam int CMD_CHAIN_BIT = 9;
  localparam int CMD_PANEL_BIT = 10;
  localparam int CTRL_TERM_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  // status byte: position 0 is the msb, so index = 7 - position
  localparam int ST_SM = 6;
  localparam int ST_CUE = 5;
  localparam int ST_BUSY = 4;
  localparam int ST_CE = 3;
  localparam int ST_DE = 2;
  localparam int ST_UC = 1;
  localparam int ST_UX = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // -------------------------------------------------------------
  // command codes
  // -------------------------------------------------------------
  localparam logic [7:0] C_WRITE = 8'h01;
  localparam logic [7:0] C_READ_FWD = 8'h02;
  localparam logic [7:0] C_READ_BWD = 8'h0c;
  localparam logic [7:0] C_SENSE = 8'h04;
  localparam logic [7:0] C_BAD_TRACK = 8'h1b;
  localparam logic [7:0] C_LOOPBACK = 8'h8b;
  localparam logic [7:0] C_REWIND = 8'h07;
  localparam logic [7:0] C_REW_UNLOAD = 8'h0f;
  localparam logic [7:0] C_WRITE_MARK = 8'h1f;
  localparam logic [7:0] C_BACK_BLOCK = 8'h27;
  localparam logic [7:0] C_BACK_FILE = 8'h2f;
  localparam logic [7:0] C_FWD_BLOCK = 8'h37;
  localparam logic [7:0] C_FWD_FILE = 8'h3f;
  localparam logic [7:0] C_ERASE_GAP = 8'h17;
  localparam logic [7:0] C_SEC_ERASE = 8'h97;
  localparam logic [7:0] C_NO_OP = 8'h03;
  localparam logic [7:0] C_DIAG_MODE = 8'h0b;
  localparam logic [7:0] C_DIAG_SET = 8'h4b;
  localparam logic [7:0] C_NINE_PE = 8'hc3;
  localparam logic [7:0] C_NINE_NRZI = 8'hcb;
  // density codes held in the mode register
  localparam logic [1:0] DEN_200 = 2'h0;
  localparam logic [1:0] DEN_556 = 2'h1;
  localparam logic [1:0] DEN_800 = 2'h2;
  localparam logic [1:0] DEN_1600 = 2'h3;
  localparam int GAP_CYCLES = 64;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    CL_BURST = 3'h0, CL_MOTION = 3'h1, CL_IMMED = 3'h2, CL_INVALID = 3'h3
  } tcc_class_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_BURST = 3'h1, S_MOTION = 3'h2, S_END_PEND = 3'h3, S_GAP = 3'h4
  } tcc_state_t;
  typedef struct packed {
    logic [1:0] density;
    logic seven_track;
    logic translator;
    logic conversion;
    logic parity_odd;
    logic phase_enc;
    logic diag;
  } tcc_mode_t;
  typedef struct packed {
    logic busy;
    logic ready;
    logic op_done;
    logic unit_check;
    logic unit_exc;
    logic file_mark;
    logic load_point;
    logic rd_valid;
    logic [7:0] rd_byte;
  } tcc_drv_in_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic cmd_strobe;
    logic [7:0] wr_byte;
    logic wr_strobe;
    logic id_burst;
    logic block_gap;
    logic trailer;
    logic convert_en;
  } tcc_drv_out_t;
endpackage

// >>> rtl/tcc_top.sv
// command decode and unit status of the tape channel port, ahb-lite slave
`timescale 1ns/1ps
module tcc_top #(
  parameter int GAP_LEN = tcc_pkg::GAP_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // tape drive side
  input wire tcc_pkg::tcc_drv_in_t drv_in,
  output tcc_pkg::tcc_drv_out_t drv_out,
  // channel attention request
  output logic chan_attn_req
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic tcc_pkg::tcc_class_t cmd_class(input logic [7:0] c);
    tcc_pkg::tcc_class_t r;
    r = tcc_pkg::CL_INVALID;
    case (c)
      tcc_pkg::C_WRITE, tcc_pkg::C_READ_FWD, tcc_pkg::C_READ_BWD, tcc_pkg::C_SENSE,
      tcc_pkg::C_BAD_TRACK, tcc_pkg::C_LOOPBACK, tcc_pkg::C_DIAG_SET: r = tcc_pkg::CL_BURST;
      tcc_pkg::C_REWIND, tcc_pkg::C_REW_UNLOAD, tcc_pkg::C_WRITE_MARK, tcc_pkg::C_BACK_BLOCK,
      tcc_pkg::C_BACK_FILE, tcc_pkg::C_FWD_BLOCK, tcc_pkg::C_FWD_FILE, tcc_pkg::C_ERASE_GAP,
      tcc_pkg::C_SEC_ERASE: r = tcc_pkg::CL_MOTION;
      tcc_pkg::C_NO_OP, tcc_pkg::C_DIAG_MODE, tcc_pkg::C_NINE_PE,
      tcc_pkg::C_NINE_NRZI: r = tcc_pkg::CL_IMMED;
      8'h13, 8'h23, 8'h2b, 8'h33, 8'h53, 8'h5b, 8'h63, 8'h6b, 8'h73, 8'h7b,
      8'h93, 8'ha3, 8'hab, 8'hb3, 8'hbb: r = tcc_pkg::CL_IMMED;
      default: r = tcc_pkg::CL_INVALID;
    endcase
    return r;
  endfunction

  // seven-track mode set: density in bits 7:6, translator bit 3
  function automatic tcc_pkg::tcc_mode_t seven_mode(input logic [7:0] c);
    tcc_pkg::tcc_mode_t m;
    m = '0;
    m.seven_track = 1'b1;
    m.density = (c[7:6] == 2'h0) ? tcc_pkg::DEN_200 :
                (c[7:6] == 2'h1) ? tcc_pkg::DEN_556 : tcc_pkg::DEN_800;
    m.translator = c[3];
    m.conversion = (c[5:4] == 2'h1) && !c[3] && !(c[7] && c[5]);
    m.parity_odd = (c[5:4] == 2'h1) || (c[5:4] == 2'h3);
    if (c == 8'h13) m.conversion = 1'b1;
    if (c == 8'h33) m.conversion = 1'b0;
    return m;
  endfunction

  function automatic logic odd_ok(input logic [8:0] b);
    return ^b;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  tcc_pkg::tcc_drv_in_t sync1_q, drv_q, prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      drv_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= drv_in;
      drv_q <= sync1_q;
      prev_q <= drv_q;
    end
  end
  wire logic done_rise = drv_q.op_done && !prev_q.op_done;
  wire logic ready_rise = drv_q.ready && !prev_q.ready;
  wire logic ready_fall = !drv_q.ready && prev_q.ready;
  wire logic rd_rise = drv_q.rd_valid && !prev_q.rd_valid;

  // ---------------------------------------------------------------
  // ahb-lite decode
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  wire logic acc = hsel && hready && htrans[1];
  wire logic rd_acc = acc && !hwrite;
  wire logic [7:0] a_lo = haddr[7:0];
  wire logic wr_cmd = wr_pend_q && (wr_addr_q == tcc_pkg::ADDR_CMD);
  wire logic wr_data = wr_pend_q && (wr_addr_q == tcc_pkg::ADDR_DATA);
  wire logic wr_ctrl = wr_pend_q && (wr_addr_q == tcc_pkg::ADDR_CTRL);
  wire logic rd_data_acc = rd_acc && (a_lo == tcc_pkg::ADDR_DATA);
  wire logic rd_end_acc = rd_acc && (a_lo == tcc_pkg::ADDR_END_STAT);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= acc && hwrite;
      wr_addr_q <= a_lo;
    end
  end

  // ---------------------------------------------------------------
  // command acceptance
  // ---------------------------------------------------------------
  tcc_pkg::tcc_state_t state_q, state_d;
  tcc_pkg::tcc_mode_t mode_q;
  logic [7:0] cmd_q, last_cmd_q, init_q, end_q;
  logic end_valid_q, busy_rep_q, check_q, exc_q, not_rdy_sel_q, bwd_q, wr_seen_q;
  logic [7:0] rd_byte_q;
  logic rd_full_q;
  logic [$clog2(GAP_LEN+1)-1:0] gap_q;

  localparam int CMD_PAR_IDX = tcc_pkg::CMD_PAR_BIT;
  wire logic [7:0] c_in = hwdata[7:0];
  wire logic par_ok = odd_ok(hwdata[CMD_PAR_IDX:0]);
  wire tcc_pkg::tcc_class_t c_class = cmd_class(c_in);
  wire logic chain_ok = hwdata[tcc_pkg::CMD_CHAIN_BIT] && (last_cmd_q == tcc_pkg::C_ERASE_GAP);
  wire logic panel = hwdata[tcc_pkg::CMD_PANEL_BIT];
  wire logic invalid = !par_ok || (c_class == tcc_pkg::CL_INVALID)
                     || ((c_in == tcc_pkg::C_SEC_ERASE) && !chain_ok)
                     || ((c_in == tcc_pkg::C_DIAG_SET) && !panel);
  wire logic ctl_busy = (state_q != tcc_pkg::S_IDLE) || end_valid_q;
  wire logic drv_busy = drv_q.busy;
  wire logic start_ok = wr_cmd && !ctl_busy && !drv_busy && !invalid;
  wire logic start_burst = start_ok && (c_class == tcc_pkg::CL_BURST);
  wire logic start_motion = start_ok && (c_class == tcc_pkg::CL_MOTION);
  wire logic start_immed = start_ok && (c_class == tcc_pkg::CL_IMMED);
  // direction follows the drive command, so conversion drops with the strobe
  wire logic bwd_d = (start_burst || start_motion) ? (c_in == tcc_pkg::C_READ_BWD) : bwd_q;

  // initial status byte
  logic [7:0] init_d;
  always_comb begin
    init_d = tcc_pkg::STAT_RESET;
    if (ctl_busy) begin
      init_d[tcc_pkg::ST_BUSY] = 1'b1;
      init_d[tcc_pkg::ST_SM] = 1'b1;
    end else if (drv_busy) begin
      init_d[tcc_pkg::ST_BUSY] = 1'b1;
    end else if (invalid) begin
      init_d[tcc_pkg::ST_UC] = 1'b1;
      init_d[tcc_pkg::ST_CE] = 1'b1;
      init_d[tcc_pkg::ST_DE] = 1'b1;
    end else if (c_class == tcc_pkg::CL_MOTION) begin
      init_d[tcc_pkg::ST_CE] = 1'b1;
    end else if (c_class == tcc_pkg::CL_IMMED) begin
      init_d[tcc_pkg::ST_CE] = 1'b1;
      init_d[tcc_pkg::ST_DE] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  wire logic is_write = (cmd_q == tcc_pkg::C_WRITE) || (cmd_q == tcc_pkg::C_LOOPBACK);
  wire logic is_read = (cmd_q == tcc_pkg::C_READ_FWD) || (cmd_q == tcc_pkg::C_READ_BWD);
  wire logic term = wr_ctrl && hwdata[tcc_pkg::CTRL_TERM_BIT];
  wire logic sel = wr_ctrl && hwdata[tcc_pkg::CTRL_SEL_BIT];
  wire logic burst_end = (state_q == tcc_pkg::S_BURST) && (term || done_rise || ready_fall);
  wire logic motion_end = (state_q == tcc_pkg::S_MOTION) && (done_rise || ready_fall);
  wire logic gap_end = (state_q == tcc_pkg::S_GAP) && (gap_q == '0);
  wire logic ready_evt = not_rdy_sel_q && ready_rise && (state_q == tcc_pkg::S_IDLE) && !end_valid_q;
  wire logic wr_par_ok = odd_ok(hwdata[8:0]);
  wire logic pass_byte = wr_data && (state_q == tcc_pkg::S_BURST) && is_write && wr_par_ok;
  wire logic mark_hit = (state_q == tcc_pkg::S_BURST) && is_read && drv_q.file_mark;
  wire logic rd_take = rd_rise && (state_q == tcc_pkg::S_BURST) && is_read && !drv_q.file_mark;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tcc_pkg::S_IDLE: begin
        if (start_burst) state_d = tcc_pkg::S_BURST;
        else if (start_motion) state_d = tcc_pkg::S_MOTION;
      end
      tcc_pkg::S_BURST: begin
        if (burst_end && is_write && wr_seen_q) state_d = tcc_pkg::S_GAP;
        else if (burst_end) state_d = tcc_pkg::S_IDLE;
      end
      tcc_pkg::S_MOTION: if (motion_end) state_d = tcc_pkg::S_END_PEND;
      tcc_pkg::S_END_PEND: if (sel) state_d = tcc_pkg::S_IDLE;
      tcc_pkg::S_GAP: if (gap_end) state_d = tcc_pkg::S_IDLE;
      default: state_d = tcc_pkg::S_IDLE;
    endcase
  end

  // ending status byte for the completing operation
  logic [7:0] end_d;
  always_comb begin
    end_d = tcc_pkg::STAT_RESET;
    end_d[tcc_pkg::ST_CE] = (state_q != tcc_pkg::S_MOTION);
    end_d[tcc_pkg::ST_DE] = 1'b1;
    end_d[tcc_pkg::ST_UC] = check_q || drv_q.unit_check;
    end_d[tcc_pkg::ST_UX] = exc_q || drv_q.unit_exc || mark_hit;
    end_d[tcc_pkg::ST_CUE] = busy_rep_q
      || ((state_q == tcc_pkg::S_MOTION) && (drv_q.unit_check || drv_q.unit_exc));
  end
  wire logic fin_burst = burst_end && !(is_write && wr_seen_q);
  wire logic fin = fin_burst || gap_end || motion_end;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_q <= tcc_pkg::S_IDLE;
    else state_q <= state_d;
  end

  // command, status and flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 8'h00;
      last_cmd_q <= 8'h00;
      init_q <= tcc_pkg::STAT_RESET;
      bwd_q <= 1'b0;
    end else if (wr_cmd) begin
      init_q <= init_d;
      if (start_ok) begin
        cmd_q <= c_in;
        bwd_q <= bwd_d;
      end
      last_cmd_q <= (start_ok) ? c_in : 8'h00;
    end
  end

  // ending status holds until read; no new command starts while it is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      end_q <= tcc_pkg::STAT_RESET;
      end_valid_q <= 1'b0;
    end else if (fin) begin
      end_q <= end_d;
      end_valid_q <= (state_q != tcc_pkg::S_MOTION);
    end else if (ready_evt) begin
      end_q <= 8'h01 << tcc_pkg::ST_DE;
      end_valid_q <= 1'b0;
    end else if (sel && (state_q == tcc_pkg::S_END_PEND)) begin
      end_valid_q <= 1'b1;
    end else if (rd_end_acc && end_valid_q) begin
      end_valid_q <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_rep_q <= 1'b0;
      check_q <= 1'b0;
      exc_q <= 1'b0;
      not_rdy_sel_q <= 1'b0;
      wr_seen_q <= 1'b0;
    end else begin
      if (wr_cmd && ctl_busy) busy_rep_q <= 1'b1;
      else if (fin) busy_rep_q <= 1'b0;
      if (wr_data && is_write && !wr_par_ok) check_q <= 1'b1;
      else if (start_ok) check_q <= 1'b0;
      if (mark_hit) exc_q <= 1'b1;
      else if (start_ok) exc_q <= 1'b0;
      if (wr_cmd && !drv_q.ready) not_rdy_sel_q <= 1'b1;
      else if (ready_evt) not_rdy_sel_q <= 1'b0;
      if (pass_byte) wr_seen_q <= 1'b1;
      else if (start_ok) wr_seen_q <= 1'b0;
    end
  end

  // mode set registers, loaded in the same cycle the initial status is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= '0;
    end else if (start_immed) begin
      if (c_in == tcc_pkg::C_NINE_PE) begin
        mode_q.seven_track <= 1'b0;
        mode_q.phase_enc <= 1'b1;
        mode_q.density <= tcc_pkg::DEN_1600;
      end else if (c_in == tcc_pkg::C_NINE_NRZI) begin
        mode_q.seven_track <= 1'b0;
        mode_q.phase_enc <= 1'b0;
        mode_q.density <= tcc_pkg::DEN_800;
      end else if (c_in == tcc_pkg::C_DIAG_MODE) begin
        mode_q.diag <= 1'b1;
      end else if (c_in != tcc_pkg::C_NO_OP) begin
        mode_q <= seven_mode(c_in) | {7'h00, mode_q.diag};
      end
    end
  end

  // ---------------------------------------------------------------
  // data paths and drive strobes
  // ---------------------------------------------------------------
  // gap length is a cycle count only; the drive sets real spacing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_q <= '0;
    else if (burst_end) gap_q <= ($clog2(GAP_LEN+1))'(GAP_LEN - 1);
    else if ((state_q == tcc_pkg::S_GAP) && (gap_q != '0)) gap_q <= gap_q - 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv_out <= '0;
    end else begin
      drv_out.cmd_strobe <= start_burst || start_motion;
      if (start_burst || start_motion) drv_out.cmd <= c_in;
      drv_out.wr_strobe <= pass_byte;
      if (pass_byte) drv_out.wr_byte <= hwdata[7:0];
      drv_out.id_burst <= start_burst && (c_in == tcc_pkg::C_WRITE)
                          && mode_q.phase_enc && drv_q.load_point;
      drv_out.block_gap <= (state_d == tcc_pkg::S_GAP);
      drv_out.trailer <= burst_end && is_write && wr_seen_q;
      drv_out.convert_en <= mode_q.conversion && !bwd_d;
    end
  end

  // read byte held until the channel takes it; overrun overwrites it with the new byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte_q <= 8'h00;
      rd_full_q <= 1'b0;
    end else if (rd_take) begin
      rd_byte_q <= drv_q.rd_byte;
      rd_full_q <= 1'b1;
    end else if (rd_data_acc) begin
      rd_full_q <= 1'b0;
    end
  end

  assign chan_attn_req = (state_q == tcc_pkg::S_END_PEND);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (a_lo)
      tcc_pkg::ADDR_INIT_STAT: rd_mux = {24'h000000, init_q};
      tcc_pkg::ADDR_END_STAT: rd_mux = {23'h000000, end_valid_q, end_q};
      tcc_pkg::ADDR_DATA: rd_mux = {23'h000000, rd_full_q, rd_byte_q};
      tcc_pkg::ADDR_MODE: rd_mux = {24'h000000, mode_q};
      tcc_pkg::ADDR_STATE: rd_mux = {16'h0000, cmd_q, 3'h0, check_q, exc_q, state_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (rd_acc) hrdata <= rd_mux;
  end
endmodule

// >>> sim/tape_channel_command_status_tb_top.sv
// self-checking bench of the tape channel command/status block
`timescale 1ns/1ps
module tape_channel_command_status_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  tcc_pkg::tcc_drv_in_t drv_in;
  tcc_pkg::tcc_drv_out_t drv_out;
  logic chan_attn_req;
  logic [7:0] dly = 8'h0;
  logic mark_en = 1'b0;
  logic busy = 1'b0;
  logic load_point = 1'b0;
  logic unready = 1'b0;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;
  int n_id = 0;
  int n_wr = 0;
  int n_trl = 0;
  tcc_top #(.GAP_LEN(4)) tcc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .drv_in(drv_in), .drv_out(drv_out), .chan_attn_req(chan_attn_req));
  tcc_drive_model tcc_drive_model_i (.hclk(hclk), .hresetn(hresetn), .drv_out(drv_out),
    .drv_in(drv_in), .dly(dly), .mark_en(mark_en), .busy(busy), .load_point(load_point),
    .unready(unready));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    n_id <= n_id + int'(drv_out.id_burst);
    n_wr <= n_wr + int'(drv_out.wr_strobe);
    n_trl <= n_trl + int'(drv_out.trailer);
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // f holds panel, chain and a parity flip
  task automatic cmd(input logic [7:0] c, input logic [2:0] f, input logic [7:0] exp);
    xfer(1'b1, tcc_pkg::ADDR_CMD, {21'h0, f[2:1], f[0] ^ ~^c, c});
    xfer(1'b0, tcc_pkg::ADDR_INIT_STAT, 32'h0);
    chk(rd & 32'hff, {24'h0, exp});
  endtask
  task automatic mset(input logic [7:0] c, input logic [31:0] m, input logic [31:0] e);
    cmd(c, 3'h0, 8'h0c);
    xfer(1'b0, tcc_pkg::ADDR_MODE, 32'h0);
    chk(rd & m, e);
  endtask
  // sel: wait for attention and select before polling ending status
  task automatic end_stat(input logic sel, input logic [31:0] m, input logic [31:0] e);
    int i;
    i = 0;
    while (sel && chan_attn_req !== 1'b1 && i < 400) begin
      @(posedge hclk);
      i++;
    end
    if (sel) chk(chan_attn_req, 1'b1);
    if (sel) xfer(1'b1, tcc_pkg::ADDR_CTRL, 32'h2);
    rd = 32'h0;
    for (i = 0; i < 100 && rd[8] !== 1'b1; i++) xfer(1'b0, tcc_pkg::ADDR_END_STAT, 32'h0);
    chk(rd & m, e);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_immediate();
    cmd(8'h03, 3'h0, 8'h0c);
    cmd(8'h0b, 3'h0, 8'h0c);
    cmd(8'h4b, 3'h0, 8'h0e);
    cmd(8'h4b, 3'h4, 8'h00);
    xfer(1'b1, tcc_pkg::ADDR_CTRL, 32'h1);
    end_stat(1'b0, 32'h1ff, 32'h10c);
    cmd(8'h03, 3'h1, 8'h0e);
    cmd(8'hff, 3'h0, 8'h0e);
    cmd(8'h97, 3'h0, 8'h0e);
    mset(8'h13, 32'hfc, 32'h2c);
    mset(8'h5b, 32'hfc, 32'h74);
    mset(8'hcb, 32'he2, 32'h80);
    mset(8'hc3, 32'he2, 32'hc2);
    $display("test immediate done");
  endtask
  task automatic t_motion();
    logic [7:0] codes [9];
    codes = '{8'h07, 8'h0f, 8'h1f, 8'h27, 8'h2f, 8'h37, 8'h3f, 8'h17, 8'h97};
    dly <= 8'h14;
    foreach (codes[k]) begin
      cmd(codes[k], {1'b0, k == 8, 1'b0}, 8'h08);
      end_stat(1'b1, 32'h1ff, 32'h104);
      chk(drv_out.cmd, codes[k]);
    end
    $display("test motion done");
  endtask
  task automatic t_busy();
    dly <= 8'h60;
    cmd(8'h37, 3'h0, 8'h08);
    cmd(8'h27, 3'h0, 8'h50);
    end_stat(1'b1, 32'h1ff, 32'h124);
    busy <= 1'b1;
    repeat (4) @(posedge hclk);
    cmd(8'h37, 3'h0, 8'h10);
    busy <= 1'b0;
    repeat (4) @(posedge hclk);
    unready <= 1'b1;
    repeat (4) @(posedge hclk);
    cmd(8'h03, 3'h0, 8'h0c);
    unready <= 1'b0;
    repeat (6) @(posedge hclk);
    xfer(1'b0, tcc_pkg::ADDR_END_STAT, 32'h0);
    chk(rd & 32'h1ff, 32'h004);
    $display("test busy done");
  endtask
  task automatic t_write();
    load_point <= 1'b1;
    dly <= 8'h0;
    // let load point through the input synchroniser first
    repeat (3) @(posedge hclk);
    cmd(8'h01, 3'h0, 8'h00);
    xfer(1'b1, tcc_pkg::ADDR_DATA, 32'h15a);
    xfer(1'b1, tcc_pkg::ADDR_DATA, 32'h007);
    xfer(1'b1, tcc_pkg::ADDR_DATA, 32'h081);
    repeat (2) @(posedge hclk);
    chk(32'(n_wr), 32'd2);
    chk(drv_out.wr_byte, 8'h07);
    xfer(1'b1, tcc_pkg::ADDR_CTRL, 32'h1);
    end_stat(1'b0, 32'h1ff, 32'h10e);
    chk(32'(n_trl), 32'd1);
    chk(32'(n_id), 32'd1);
    load_point <= 1'b0;
    $display("test write done");
  endtask
  task automatic t_read(input logic [7:0] c, input logic m, input logic cv, input logic [31:0] e);
    int i;
    mark_en <= m;
    dly <= 8'h18;
    cmd(c, 3'h0, 8'h00);
    rd = 32'h0;
    for (i = 0; i < 60 && rd[8] !== 1'b1; i++) xfer(1'b0, tcc_pkg::ADDR_DATA, 32'h0);
    chk(rd & 32'h1ff, 32'h1a5);
    chk(drv_out.convert_en, cv);
    end_stat(1'b0, 32'h1ff, e);
    xfer(1'b0, tcc_pkg::ADDR_DATA, 32'h0);
    chk(rd & 32'h100, 32'h0);
    $display("test read done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_immediate();
    t_motion();
    t_busy();
    t_write();
    mset(8'h13, 32'hfc, 32'h2c);
    t_read(8'h02, 1'b0, 1'b1, 32'h10c);
    t_read(8'h0c, 1'b1, 1'b0, 32'h10d);
    stop_test();
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule

// >>> sim/tcc_checker.sv
// port assertions of the tape channel command/status block
`timescale 1ns/1ps
module tcc_checker #(
  parameter int GAP_LEN = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // drive and channel side
  input wire tcc_pkg::tcc_drv_out_t drv_out,
  input wire logic chan_attn_req
);
  // ---------------------------------------------
  // gap length counter
  // ---------------------------------------------
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  assign gap_d = drv_out.block_gap ? gap_q + 8'h1 : 8'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_q <= 8'h0;
    else gap_q <= gap_d;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_strobe_code: assert property (drv_out.cmd_strobe |-> drv_out.cmd inside {8'h01, 8'h02,
    8'h0c, 8'h04, 8'h1b, 8'h8b, 8'h4b, 8'h07, 8'h0f, 8'h1f, 8'h27, 8'h2f, 8'h37, 8'h3f,
    8'h17, 8'h97}) else $error("strobe with a non-executing code");
  a_strobe_pulse: assert property (drv_out.cmd_strobe |=> !drv_out.cmd_strobe)
    else $error("command strobe longer than one cycle");
  a_wr_pulse: assert property (drv_out.wr_strobe |=> !drv_out.wr_strobe)
    else $error("write strobe longer than one cycle");
  a_wr_cmd: assert property (drv_out.wr_strobe |-> drv_out.cmd inside {8'h01, 8'h8b})
    else $error("write byte outside a write command");
  a_conv_bwd: assert property (drv_out.cmd == 8'h0c |-> !drv_out.convert_en)
    else $error("conversion on in backward read");
  a_gap_len: assert property ($fell(drv_out.block_gap) |-> gap_q == GAP_LEN)
    else $error("block gap of wrong length");
  a_attn_hold: assert property ($rose(chan_attn_req) |=> chan_attn_req [*2])
    else $error("attention dropped before selection");
  c_strobe: cover property (drv_out.cmd_strobe);
  c_attn: cover property ($rose(chan_attn_req));
  c_trailer: cover property (drv_out.trailer);
  c_id: cover property (drv_out.id_burst);
endmodule
bind tcc_top tcc_checker #(.GAP_LEN(GAP_LEN)) tcc_checker_i (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .drv_out(drv_out), .chan_attn_req(chan_attn_req));

// >>> sim/tcc_drive_model.sv
// behavioural tape drive answering the block's command strobes
`timescale 1ns/1ps
module tcc_drive_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // block side
  input wire tcc_pkg::tcc_drv_out_t drv_out,
  output tcc_pkg::tcc_drv_in_t drv_in,
  // bench controls
  input wire logic [7:0] dly,
  input wire logic mark_en,
  input wire logic busy,
  input wire logic load_point,
  input wire logic unready
);
  logic [7:0] t_q;
  // delay latched per command so a bench change never fakes a finish edge
  logic [7:0] dly_q;
  logic run_q;
  logic rd_v;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_q <= 8'h0;
      run_q <= 1'b0;
      dly_q <= 8'h0;
    end else if (drv_out.cmd_strobe) begin
      t_q <= 8'h0;
      run_q <= 1'b1;
      dly_q <= dly;
    end else if (t_q != 8'hff) begin
      t_q <= t_q + 8'h1;
    end
  end
  // two-cycle valid so the synchroniser sees one clean rise
  assign rd_v = run_q && (t_q[7:1] == 7'h2 || (mark_en && t_q[7:1] == 7'h6));
  always_comb begin
    drv_in = '0;
    drv_in.busy = busy;
    drv_in.ready = !unready;
    drv_in.load_point = load_point;
    // zero delay means no finish: writes end by channel terminate
    drv_in.op_done = run_q && dly_q != 8'h0 && t_q >= dly_q;
    drv_in.file_mark = run_q && mark_en && t_q >= 8'ha;
    drv_in.rd_valid = rd_v;
    // idle byte lines toggle so a stale byte never looks like data
    drv_in.rd_byte = rd_v ? (t_q < 8'h8 ? 8'ha5 : 8'h13) : t_q;
  end
endmodule
